// *** madbg_pkg.sv ***
`default_nettype none

package madbg_pkg;

    // Register port geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Offset of the debug override register.
    localparam logic [ADDR_W-1:0] MADBG_OFFSET = 8'hee;

    // Reset value of every field.
    localparam logic [DATA_W-1:0] MADBG_RESET = 32'h0000_0000;

    // Field positions inside the 32-bit word.
    localparam int SECTOR_LSB   = 28;
    localparam int SECTOR_W     = 3;
    localparam int STOP_DIS_BIT = 27;
    localparam int BYPASS_BIT   = 26;
    localparam int VD_LSB       = 16;
    localparam int VQ_LSB       = 6;
    localparam int CODE_W       = 10;
    localparam int START_BIT    = 5;
    localparam int MEAS_LSB     = 1;
    localparam int MEAS_W       = 4;
    localparam int SHADOW_BIT   = 0;

    // Voltage command encoding.
    localparam int REF_W = CODE_W + 1;
    localparam logic [CODE_W-1:0] CODE_POS_MAX = 10'h1f4;
    localparam logic [CODE_W-1:0] CODE_NEG_MIN = 10'h200;
    localparam logic [REF_W-1:0]  CODE_BIAS    = 11'h400;

    // Sector codes that both mean the last sector before the stop.
    localparam logic [SECTOR_W-1:0] SECTOR_LAST_LO = 3'h0;
    localparam logic [SECTOR_W-1:0] SECTOR_LAST_HI = 3'h7;

    // One write on the register port.
    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } madbg_wr_t;

    // Stored settings of the register.
    typedef struct packed {
        logic [SECTOR_W-1:0] recirc_sector;
        logic                recirc_stop_dis;
        logic                inner_loop_bypass;
        logic [MEAS_W-1:0]   measure_en;
    } madbg_ctrl_t;

    // State of the register bank apart from the two voltage references, which the decoders hold.
    typedef struct packed {
        madbg_ctrl_t ctrl;
        logic        start_pulse;
        logic        shadow_pulse;
    } madbg_state_t;

    // State of one voltage decoder.
    typedef struct packed {
        logic signed [REF_W-1:0] ref_val;
    } madbg_dec_state_t;

endpackage : madbg_pkg

`default_nettype wire

// *** madbg_volt_decode.sv ***
`timescale 1ns/10ps
`default_nettype none

// Turns a 10-bit forced-voltage code into a signed reference in 1/500 steps.
module madbg_volt_decode (
    input  wire logic                             i_ref_clk,
    input  wire logic                             i_reset_n,
    input  wire logic                             i_load,
    input  wire logic [madbg_pkg::CODE_W-1:0]     i_code,
    output logic signed [madbg_pkg::REF_W-1:0]    o_ref
);
    import madbg_pkg::*;

    madbg_dec_state_t state_q;   // Registered state.
    madbg_dec_state_t state_d;   // Next state.
    logic             code_low;  // Code in the positive range.
    logic             code_high; // Code in the negative range.

    ////////////////////////////////////////////////////////////////////////
    // Decode. The gap codes keep the old command so a typo never kicks the
    // motor with an undefined voltage.
    always_comb
    begin
        code_low  = (i_code <= CODE_POS_MAX);
        code_high = (i_code >= CODE_NEG_MIN);
        state_d   = state_q;
        if (i_load && code_low)
        begin
            state_d.ref_val = signed'({1'b0, i_code});
        end
        else if (i_load && code_high)
        begin
            state_d.ref_val = signed'({1'b0, i_code} - CODE_BIAS);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    assign o_ref = state_q.ref_val;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    a_pos_code: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_load && i_code <= CODE_POS_MAX) |=> (o_ref == signed'({1'b0, $past(i_code)})))
        else $error("Positive voltage code decoded wrongly.");
    a_neg_code: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_load && i_code >= CODE_NEG_MIN) |=> (o_ref < 0) && (o_ref + CODE_BIAS == signed'({1'b0, $past(i_code)})))
        else $error("Negative voltage code decoded wrongly.");
    a_gap_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_load && i_code > CODE_POS_MAX && i_code < CODE_NEG_MIN) |=> $stable(o_ref))
        else $error("Invalid voltage code changed the command.");

endmodule : madbg_volt_decode

`default_nettype wire

// *** madbg_override_reg.sv ***
`timescale 1ns/10ps
`default_nettype none

module madbg_override_reg (
    input  wire logic                               i_ref_clk,
    input  wire logic                               i_reset_n,
    input  wire madbg_pkg::madbg_wr_t               i_reg_wr,
    output logic [madbg_pkg::SECTOR_W-1:0]          o_recirc_sector,
    output logic                                    o_recirc_use_last,
    output logic                                    o_recirc_stop_en,
    output logic                                    o_inner_loop_bypass,
    output logic                                    o_speed_loop_bypass,
    output logic signed [madbg_pkg::REF_W-1:0]      o_forced_direct_axis_voltage,
    output logic signed [madbg_pkg::REF_W-1:0]      o_forced_quadrature_axis_voltage,
    output logic                                    o_param_measure_start,
    output logic                                    o_measure_resistance_enable,
    output logic                                    o_measure_inductance_enable,
    output logic                                    o_measure_backemf_enable,
    output logic                                    o_measure_mechanical_enable,
    output logic                                    o_measured_params_to_shadow
);
    import madbg_pkg::*;

    // Stored control fields and command strobes share one state word, so one register stage owns them all.
    madbg_state_t                  state_q;           // Registered state.
    madbg_state_t                  state_d;           // Next state.
    logic                          wr_hit;            // Write aimed at this register.
    logic [1:0][CODE_W-1:0]        axis_code;         // Direct then quadrature code.
    logic signed [1:0][REF_W-1:0]  axis_ref;          // Decoded references.

    ////////////////////////////////////////////////////////////////////////
    // Address decode. Writes to other offsets belong to neighbours.
    // There is no read path, so the strobe and the offset are all that
    // qualify a write; the data word only matters on a hit.
    always_comb
    begin
        if (i_reg_wr.en && (i_reg_wr.addr == MADBG_OFFSET))
        begin
            // Strobe and offset agree: this word is ours.
            wr_hit = 1'b1;
        end
        else
        begin
            // Idle cycle or a neighbour's offset.
            wr_hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state. Command bits are strobes: they fire for one cycle on the
    // write and are not stored, since nothing can read them back anyway.
    // Bit 31 is reserved and dropped; the voltage fields live in the decoders.
    always_comb
    begin
        state_d              = state_q;
        state_d.start_pulse  = 1'b0;
        state_d.shadow_pulse = 1'b0;
        if (wr_hit)
        begin
            state_d.ctrl.recirc_sector     = i_reg_wr.data[SECTOR_LSB +: SECTOR_W];
            state_d.ctrl.recirc_stop_dis   = i_reg_wr.data[STOP_DIS_BIT];
            state_d.ctrl.inner_loop_bypass = i_reg_wr.data[BYPASS_BIT];
            state_d.ctrl.measure_en        = i_reg_wr.data[MEAS_LSB +: MEAS_W];
            state_d.start_pulse            = i_reg_wr.data[START_BIT];
            state_d.shadow_pulse           = i_reg_wr.data[SHADOW_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; all fields come up as zero.
    // The clear is asynchronous so no stale override reaches the motor before the clock runs.
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Voltage decoders, one per axis.
    // Both decoders see every hit; each holds its own axis on a gap code,
    // so a bad code on one axis never blocks a good code on the other.
    assign axis_code[0] = i_reg_wr.data[VD_LSB +: CODE_W];
    assign axis_code[1] = i_reg_wr.data[VQ_LSB +: CODE_W];

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_axis
            madbg_volt_decode u_dec (
                .i_ref_clk (i_ref_clk),
                .i_reset_n (i_reset_n),
                .i_load    (wr_hit),
                .i_code    (axis_code[g]),
                .o_ref     (axis_ref[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Outputs. The loop bypass kills both loops together; the consumer takes
    // the forced voltages only while the bypass is high.
    // The last-sector decode sits beside the raw code so the stop logic needs no table.
    // raw sector code.
    assign o_recirc_sector   = state_q.ctrl.recirc_sector;
    assign o_recirc_use_last = (state_q.ctrl.recirc_sector == SECTOR_LAST_LO) ||
                               (state_q.ctrl.recirc_sector == SECTOR_LAST_HI);
    assign o_recirc_stop_en  = ~state_q.ctrl.recirc_stop_dis;
    assign o_inner_loop_bypass = state_q.ctrl.inner_loop_bypass;
    assign o_speed_loop_bypass = state_q.ctrl.inner_loop_bypass;

    assign o_forced_direct_axis_voltage     = axis_ref[0];
    assign o_forced_quadrature_axis_voltage = axis_ref[1];

    assign o_param_measure_start            = state_q.start_pulse;

    assign o_measure_resistance_enable      = state_q.ctrl.measure_en[3];
    assign o_measure_inductance_enable      = state_q.ctrl.measure_en[2];
    assign o_measure_backemf_enable         = state_q.ctrl.measure_en[1];
    assign o_measure_mechanical_enable      = state_q.ctrl.measure_en[0];
    assign o_measured_params_to_shadow      = state_q.shadow_pulse;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);
    // Attempts are cut while reset is low; the bench looks at the reset values itself.

    a_other_addr: assert property (
        (i_reg_wr.en && i_reg_wr.addr != MADBG_OFFSET) |=> $stable(state_q.ctrl) && !o_param_measure_start)
        else $error("Write to another offset changed the register.");
    a_sector_map: assert property (
        wr_hit |=> (o_recirc_sector == $past(i_reg_wr.data[30:28])) &&
                   (o_recirc_use_last == ($past(i_reg_wr.data[30:28]) inside {3'h0, 3'h7})))
        else $error("Recirculation sector mapped wrongly.");
    a_stop_invert: assert property (
        wr_hit |=> o_recirc_stop_en == !$past(i_reg_wr.data[27]))
        else $error("Recirculation stop enable has wrong polarity.");
    a_loop_bypass: assert property (
        wr_hit |=> (o_inner_loop_bypass == $past(i_reg_wr.data[26])) && (o_speed_loop_bypass == o_inner_loop_bypass))
        else $error("Loop bypass does not follow the write.");
    a_start_pulse: assert property (
        (wr_hit && i_reg_wr.data[5]) |=> o_param_measure_start ##1 (o_param_measure_start == $past(wr_hit && i_reg_wr.data[5])))
        else $error("Measurement start strobe wrong.");
    a_meas_res: assert property (
        wr_hit |=> o_measure_resistance_enable == $past(i_reg_wr.data[4]))
        else $error("Resistance select wrong.");
    a_meas_ind: assert property (
        wr_hit |=> o_measure_inductance_enable == $past(i_reg_wr.data[3]))
        else $error("Inductance select wrong.");
    a_meas_bemf: assert property (
        wr_hit |=> o_measure_backemf_enable == $past(i_reg_wr.data[2]))
        else $error("Back-EMF select wrong.");
    a_meas_mech: assert property (
        wr_hit |=> o_measure_mechanical_enable == $past(i_reg_wr.data[1]))
        else $error("Mechanical select wrong.");
    a_shadow_pulse: assert property (
        o_measured_params_to_shadow |-> $past(wr_hit && i_reg_wr.data[0]))
        else $error("Shadow copy strobe without a write.");

    // Top-level views of the voltage fields; the decoder checks every code itself.
    a_vd_follow: assert property (
        (wr_hit && axis_code[0] <= CODE_POS_MAX) |=>
            o_forced_direct_axis_voltage == signed'({1'b0, $past(axis_code[0])}))
        else $error("Forced direct-axis voltage does not follow the write.");
    a_vq_negative: assert property (
        (wr_hit && axis_code[1] >= CODE_NEG_MIN) |=> (o_forced_quadrature_axis_voltage < 0) &&
            ((o_forced_quadrature_axis_voltage + CODE_BIAS) == {1'b0, $past(axis_code[1])}))
        else $error("Forced quadrature-axis voltage does not follow the write.");
    a_vd_gap_hold: assert property (
        (wr_hit && axis_code[0] > CODE_POS_MAX && axis_code[0] < CODE_NEG_MIN) |=>
            $stable(o_forced_direct_axis_voltage))
        else $error("Gap code changed the forced direct-axis voltage.");
    a_vq_gap_hold: assert property (
        (wr_hit && axis_code[1] > CODE_POS_MAX && axis_code[1] < CODE_NEG_MIN) |=>
            $stable(o_forced_quadrature_axis_voltage))
        else $error("Gap code changed the forced quadrature-axis voltage.");

    // With no hit nothing may move and both strobes must be low.
    a_idle_hold: assert property (
        !wr_hit |=> $stable(state_q.ctrl) && $stable(o_forced_direct_axis_voltage) &&
            $stable(o_forced_quadrature_axis_voltage))
        else $error("Register changed without a write.");
    a_strobe_drop: assert property (
        !wr_hit |=> !o_param_measure_start && !o_measured_params_to_shadow)
        else $error("Command strobe without a write.");

    c_bypass_on:   cover property (wr_hit && i_reg_wr.data[26] ##1 o_inner_loop_bypass);
    c_meas_start:  cover property (o_param_measure_start && o_measure_resistance_enable);
    c_shadow_copy: cover property (o_measured_params_to_shadow);
    c_neg_voltage: cover property (o_forced_quadrature_axis_voltage < 0);
    c_gap_code:    cover property (wr_hit && axis_code[0] > CODE_POS_MAX && axis_code[0] < CODE_NEG_MIN);

endmodule : madbg_override_reg

`default_nettype wire

// *** madbg_override_reg_test.sv ***
`timescale 1ns/10ps
`default_nettype none

// Self-checking bench for the debug override register, driven through its write strobe group.
module madbg_override_reg_test;
    import madbg_pkg::*;

    logic                    i_ref_clk;   // Bench clock, 50 MHz.
    logic                    i_reset_n;   // Asynchronous reset, active low.
    madbg_wr_t               wr_q;        // Write strobe, address and data.
    logic [2:0]              sec;         // Stored sector code.
    logic                    use_last;    // Last-sector decode.
    logic                    stop_en;     // Forced recirculation stop enable.
    logic                    ibyp;        // Current loop bypass.
    logic                    sbyp;        // Speed loop bypass.
    logic signed [REF_W-1:0] vd;          // Forced direct-axis reference.
    logic signed [REF_W-1:0] vq;          // Forced quadrature-axis reference.
    logic                    start;       // Measurement start pulse.
    logic [3:0]              meas;        // Measurement selects, resistance first.
    logic                    shadow;      // Shadow copy pulse.
    logic [34:0]             obs;         // Every output packed for one compare.
    logic [DATA_W-1:0]       m_word;      // Last word the model accepted.
    logic signed [REF_W-1:0] m_vd;        // Model direct-axis reference.
    logic signed [REF_W-1:0] m_vq;        // Model quadrature-axis reference.
    logic [CODE_W-1:0]       codes [10];  // Voltage codes across every range boundary.
    int                      err_count;   // Mismatches seen.
    int                      checks_done; // Compares made.

    madbg_override_reg DUT (
        .i_ref_clk                        (i_ref_clk),
        .i_reset_n                        (i_reset_n),
        .i_reg_wr                         (wr_q),
        .o_recirc_sector                  (sec),
        .o_recirc_use_last                (use_last),
        .o_recirc_stop_en                 (stop_en),
        .o_inner_loop_bypass              (ibyp),
        .o_speed_loop_bypass              (sbyp),
        .o_forced_direct_axis_voltage     (vd),
        .o_forced_quadrature_axis_voltage (vq),
        .o_param_measure_start            (start),
        .o_measure_resistance_enable      (meas[3]),
        .o_measure_inductance_enable      (meas[2]),
        .o_measure_backemf_enable         (meas[1]),
        .o_measure_mechanical_enable      (meas[0]),
        .o_measured_params_to_shadow      (shadow)
    );

    assign obs = {sec, use_last, stop_en, ibyp, sbyp, vd, vq, start, meas, shadow};

    ////////////////////////////////////////////////////////////////////////////////
    // Decodes a code the way the rules read; out-of-range codes keep the old value.
    function automatic logic signed [REF_W-1:0] dec(input logic [CODE_W-1:0] c, input logic signed [REF_W-1:0] p);
        if (c <= CODE_POS_MAX)
            return {1'b0, c};
        if (c >= CODE_NEG_MIN)
            return {1'b0, c} - CODE_BIAS;
        return p;
    endfunction : dec

    // Builds the expected outputs from the model; pulses only count on the cycle after a write.
    function automatic logic [34:0] exp_out(input logic pulse);
        logic [2:0] s;
        s = m_word[30:28];
        return {s, (s == SECTOR_LAST_LO) || (s == SECTOR_LAST_HI), ~m_word[27], m_word[26], m_word[26],
                m_vd, m_vq, pulse & m_word[5], m_word[4:1], pulse & m_word[0]};
    endfunction : exp_out

    // Counts one compare and reports a mismatch at once.
    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One write, then the pulse cycle and the settled cycle are both compared.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_ref_clk);
        wr_q <= '{1'b1, a, d};
        @(posedge i_ref_clk);
        wr_q.en <= 1'b0;
        if (a == MADBG_OFFSET)
        begin
            m_vd   = dec(d[25:16], m_vd);
            m_vq   = dec(d[15:6], m_vq);
            m_word = d;
        end
        #1;
        check(obs, exp_out(a == MADBG_OFFSET));
        @(posedge i_ref_clk);
        #1;
        check(obs, exp_out(1'b0));
    endtask : wr

    // Prints the verdict and stops; the watchdog ends here as well.
    task automatic test_done();
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    // Free-running clock, 20 ns period.
    initial
    begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    // Watchdog sized well above the roughly 112 cycles the sequence needs.
    initial
    begin
        repeat (5000) @(posedge i_ref_clk);
        err_count++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        i_reset_n   = 1'b0;
        wr_q        = '0;
        m_word      = '0;
        m_vd        = '0;
        m_vq        = '0;
        err_count   = 0;
        checks_done = 0;
        codes = '{10'h000, 10'h001, 10'h1f4, 10'h1f5, 10'h1ff, 10'h200, 10'h20c, 10'h3e8, 10'h3ff, 10'h005};
        repeat (10) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        #1;
        check(obs, exp_out(1'b0));
        // every sector code, with the stop bit toggling.
        for (int s = 0; s < 8; s++)
            wr(MADBG_OFFSET, {1'b0, 3'(s), 1'(s), 27'h0});
        // voltage codes at the range boundaries.
        for (int i = 0; i < 10; i++)
            wr(MADBG_OFFSET, {5'h00, 1'b1, codes[i], codes[9 - i], 6'h00});
        foreach (codes[i])
            wr(MADBG_OFFSET, 32'h0000_0001 << ((i < 4) ? i + 1 : (i < 6) ? 26 : 31));
        wr(MADBG_OFFSET, 32'h0000_0021);
        wr(8'hef, 32'hffff_ffff);
        wr(8'hed, 32'h7fff_ffdf);
        @(posedge i_ref_clk);
        wr_q <= '{1'b1, MADBG_OFFSET, 32'h1c00_0001};
        @(posedge i_ref_clk);
        wr_q.data <= 32'h0000_0020;
        m_word = 32'h1c00_0001;
        m_vd   = '0;
        m_vq   = '0;
        #1;
        check(obs, exp_out(1'b1));
        @(posedge i_ref_clk);
        wr_q.en <= 1'b0;
        m_word = 32'h0000_0020;
        #1;
        check(obs, exp_out(1'b1));
        // reset in mid-run clears every field.
        wr(MADBG_OFFSET, 32'h3c7f_fdfe);
        @(posedge i_ref_clk);
        i_reset_n <= 1'b0;
        m_word = '0;
        m_vd   = '0;
        m_vq   = '0;
        #1;
        check(obs, exp_out(1'b0));
        @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        @(posedge i_ref_clk);
        #1;
        check(obs, exp_out(1'b0));
        test_done();
    end

endmodule : madbg_override_reg_test

`default_nettype wire
